/* shared/setting_id_params.svh */
// Offsets, field positions, reset values and timing counts for the latched
// setting and identification register group.
// Assumes an 8-bit register address space reached by the serial front end.
`ifndef SETTING_ID_PARAMS_SVH
`define SETTING_ID_PARAMS_SVH

`define OFS_PENDING_DISABLE    8'h1C
`define OFS_PENDING_RANGE      8'h1D
`define OFS_ACTIVE_DISABLE     8'h22
`define OFS_ACTIVE_RANGE       8'h23
`define OFS_LATCHED_DISABLE    8'h25
`define OFS_LATCHED_RANGE      8'h26
`define OFS_PRODUCT_IDENTIFIER         8'hFD
`define OFS_MAKER_ID           8'hFE
`define OFS_DIE_REVISION_IDENTIFIER        8'hFF

`define SKIP_MSB               7
`define SKIP_LSB               4
`define SENSE_MSB              7
`define SENSE_LSB              4
`define BUSV_MSB               3
`define BUSV_LSB               0

`define RESET_DISABLE          8'h00
`define RESET_RANGE            8'h00

`define SETTLE_TIME_US         1000
`define CLK_PERIOD_NS          100
`define SETTLE_CYCLES          ((`SETTLE_TIME_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* shared/setting_id_pkg.sv */
// Types shared by the latched setting and identification register group.
// Assumes nothing beyond the device clock domain.
package setting_id_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef logic [3:0] chan_bits_t;
  typedef enum logic [1:0] {
    RANGE_UNIPOLAR_BIN,
    RANGE_BIPOLAR_TWOS
  } range_code_e;
endpackage

/* hdl/latched_setting_and_id_regs.sv */
// Latched setting snapshots and fixed identification bytes of a four-channel
// power monitor. Assumes the serial front end presents one-cycle read/write
// strobes with an 8-bit address, all synchronous to sys_clk.
`timescale 1ns/1ps
`include "setting_id_params.svh"

module latched_setting_and_id_regs #(
  parameter int                        CHANNELS     = 4,
  parameter setting_id_pkg::reg_byte_t PRODUCT_CODE = 8'h2A,  // Arbitrary value
  parameter setting_id_pkg::reg_byte_t MAKER_CODE   = 8'h3C,  // Arbitrary value
  parameter setting_id_pkg::reg_byte_t DIE_REV_CODE = 8'h07,  // Arbitrary value
  parameter int                        SETTLE_COUNT = `SETTLE_CYCLES
) (
  input  wire logic                      sys_clk,
  input  wire logic                      resetn,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  input  wire setting_id_pkg::reg_byte_t reg_addr,
  input  wire setting_id_pkg::reg_byte_t reg_wdata,
  input  wire logic                      refresh,
  output setting_id_pkg::reg_byte_t      reg_rdata,
  output logic                           reg_hit,
  output setting_id_pkg::chan_bits_t     channel_skip_bit,
  output setting_id_pkg::chan_bits_t     sense_bipolar_bit,
  output setting_id_pkg::chan_bits_t     busv_bipolar_bit,
  output logic                           latched_valid
);
  import setting_id_pkg::*;

  reg_byte_t pending_disable;
  reg_byte_t pending_range;
  reg_byte_t active_channel_disable;
  reg_byte_t active_bidirectional_range;
  reg_byte_t latched_channel_disable;
  reg_byte_t latched_bidirectional_range;
  logic [$clog2(SETTLE_COUNT+1)-1:0] settle_cnt;

  wire sel_pend_dis  = (reg_addr == `OFS_PENDING_DISABLE);
  wire sel_pend_rng  = (reg_addr == `OFS_PENDING_RANGE);
  wire sel_act_dis   = (reg_addr == `OFS_ACTIVE_DISABLE);
  wire sel_act_rng   = (reg_addr == `OFS_ACTIVE_RANGE);
  wire sel_lat_dis   = (reg_addr == `OFS_LATCHED_DISABLE);
  wire sel_lat_rng   = (reg_addr == `OFS_LATCHED_RANGE);
  wire sel_product   = (reg_addr == `OFS_PRODUCT_IDENTIFIER);
  wire sel_maker     = (reg_addr == `OFS_MAKER_ID);
  wire sel_revision  = (reg_addr == `OFS_DIE_REVISION_IDENTIFIER);
  wire any_sel       = sel_pend_dis | sel_pend_rng | sel_act_dis | sel_act_rng |
                       sel_lat_dis | sel_lat_rng | sel_product | sel_maker |
                       sel_revision;

  // Only the pending pair accepts writes; everything else here is read-only
  wire wr_pend_dis   = reg_wr & sel_pend_dis;
  wire wr_pend_rng   = reg_wr & sel_pend_rng;

  // Disable keeps only the channel nibble, so the low bits can never leak
  wire reg_byte_t pend_dis_masked = {reg_wdata[`SKIP_MSB:`SKIP_LSB], 4'h0};

  wire reg_byte_t next_rdata =
      sel_pend_dis ? pending_disable :
      sel_pend_rng ? pending_range :
      sel_act_dis  ? active_channel_disable :
      sel_act_rng  ? active_bidirectional_range :
      sel_lat_dis  ? latched_channel_disable :
      sel_lat_rng  ? latched_bidirectional_range :
      sel_product  ? PRODUCT_CODE :
      sel_maker    ? MAKER_CODE :
      sel_revision ? DIE_REV_CODE :
      8'h00;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pending_disable <= `RESET_DISABLE;
      pending_range   <= `RESET_RANGE;
    end else begin
      if (wr_pend_dis) begin
        pending_disable <= pend_dis_masked;
      end
      if (wr_pend_rng) begin
        pending_range <= reg_wdata;
      end
    end
  end

  // A write and a refresh in one cycle: the refresh takes the old pending value
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      active_channel_disable     <= `RESET_DISABLE;
      active_bidirectional_range <= `RESET_RANGE;
      latched_channel_disable    <= `RESET_DISABLE;
      latched_bidirectional_range <= `RESET_RANGE;
    end else if (refresh) begin
      active_channel_disable      <= pending_disable;
      active_bidirectional_range  <= pending_range;
      latched_channel_disable     <= active_channel_disable;
      latched_bidirectional_range <= active_bidirectional_range;
    end
  end

  // Read data is registered; reads change no state
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
      reg_hit   <= 1'b0;
    end else begin
      reg_hit <= reg_rd & any_sel;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // Settle counter mirrors the window the host must wait before trusting latches
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      settle_cnt <= '0;
    end else if (refresh) begin
      settle_cnt <= ($clog2(SETTLE_COUNT+1))'(SETTLE_COUNT);
    end else if (settle_cnt != '0) begin
      settle_cnt <= settle_cnt - 1'b1;
    end
  end

  assign latched_valid = (settle_cnt == '0);

  // Channel n sits at the MSB side: bit 7, or bit 3 for the bus voltage field, is channel one
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
    assign channel_skip_bit[ch]  = latched_channel_disable[`SKIP_MSB - ch];
    assign sense_bipolar_bit[ch] = latched_bidirectional_range[`SENSE_MSB - ch];
    assign busv_bipolar_bit[ch]  = latched_bidirectional_range[`BUSV_MSB - ch];
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  // Refresh chain: latches take the settings that were active before the edge
  a_latch_dis_copy: assert property (
    refresh |=> latched_channel_disable == $past(active_channel_disable))
    else $error("latched disable did not take prior active value");

  a_latch_rng_copy: assert property (
    refresh |=> latched_bidirectional_range == $past(active_bidirectional_range))
    else $error("latched range did not take prior active value");

  a_lat_dis_hold: assert property (
    !refresh |=> $stable(latched_channel_disable))
    else $error("latched disable changed without refresh");

  a_lat_rng_hold: assert property (
    !refresh |=> $stable(latched_bidirectional_range))
    else $error("latched range changed without refresh");

  a_pend_no_effect: assert property (
    !refresh |=> $stable(active_channel_disable) && $stable(active_bidirectional_range))
    else $error("active settings changed without refresh");

  a_active_from_pend: assert property (
    refresh |=> active_channel_disable == $past(pending_disable) &&
                active_bidirectional_range == $past(pending_range))
    else $error("active settings did not take pending values");

  a_pend_range_write: assert property (
    wr_pend_rng |=> pending_range == $past(reg_wdata))
    else $error("pending range write lost");

  // Settle window seen by the host
  a_valid_after_wait: assert property (
    refresh |=> !latched_valid [*8])
    else $error("latched valid too early after refresh");

  a_settle_counts: assert property (
    settle_cnt != '0 && !refresh |=> settle_cnt == $past(settle_cnt) - 1'b1)
    else $error("settle counter did not step down");

  a_valid_stays: assert property (
    latched_valid && !refresh |=> latched_valid)
    else $error("latched valid dropped without refresh");

  // Bit order of the per-channel views
  a_skip_map_order: assert property (
    channel_skip_bit[0] == latched_channel_disable[7] &&
    channel_skip_bit[3] == latched_channel_disable[4])
    else $error("channel skip order wrong");

  a_skip_map_mid: assert property (
    channel_skip_bit[1] == latched_channel_disable[6] &&
    channel_skip_bit[2] == latched_channel_disable[5])
    else $error("channel skip middle bits wrong");

  a_low_nibble_zero: assert property (
    reg_rd && sel_lat_dis |=> reg_rdata[3:0] == 4'h0)
    else $error("latched disable low nibble not zero");

  a_lat_low_zero: assert property (
    latched_channel_disable[3:0] == 4'h0 && pending_disable[3:0] == 4'h0)
    else $error("disable low nibble held a one");

  a_range_split: assert property (
    sense_bipolar_bit[0] == latched_bidirectional_range[7] &&
    busv_bipolar_bit[0] == latched_bidirectional_range[3])
    else $error("range field split wrong");

  a_range_mid: assert property (
    sense_bipolar_bit[1] == latched_bidirectional_range[6] &&
    sense_bipolar_bit[2] == latched_bidirectional_range[5] &&
    busv_bipolar_bit[1] == latched_bidirectional_range[2] &&
    busv_bipolar_bit[2] == latched_bidirectional_range[1])
    else $error("range middle bits wrong");

  a_sense_fourth: assert property (
    sense_bipolar_bit[3] == latched_bidirectional_range[4])
    else $error("sense channel four bit wrong");

  a_busv_fourth: assert property (
    busv_bipolar_bit[3] == latched_bidirectional_range[0])
    else $error("bus channel four bit wrong");

  // Read port
  a_lat_dis_read: assert property (
    reg_rd && sel_lat_dis |=> reg_rdata == $past(latched_channel_disable))
    else $error("latched disable read wrong");

  a_lat_rng_read: assert property (
    reg_rd && sel_lat_rng |=> reg_rdata == $past(latched_bidirectional_range))
    else $error("latched range read wrong");

  a_product_read: assert property (
    reg_rd && sel_product |=> reg_rdata == PRODUCT_CODE)
    else $error("product code read wrong");

  a_maker_read: assert property (
    reg_rd && sel_maker |=> reg_rdata == MAKER_CODE)
    else $error("maker code read wrong");

  a_revision_read: assert property (
    reg_rd && sel_revision |=> reg_rdata == DIE_REV_CODE)
    else $error("revision code read wrong");

  a_hit_mapped: assert property (
    reg_rd && any_sel |=> reg_hit)
    else $error("mapped read gave no hit");

  a_hit_unmapped: assert property (
    reg_rd && !any_sel |=> !reg_hit && reg_rdata == 8'h00)
    else $error("unmapped read not zero without hit");

  a_hit_one_cycle: assert property (
    !reg_rd |=> !reg_hit)
    else $error("hit without a read");

  a_rdata_holds: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");

  // Reads change nothing, writes reach only the pending pair
  a_read_no_side: assert property (
    reg_rd && !reg_wr && !refresh |=> $stable(pending_disable) && $stable(pending_range))
    else $error("read altered pending settings");

  a_write_ignored: assert property (
    reg_wr && sel_lat_dis && !refresh |=> $stable(latched_channel_disable))
    else $error("write altered latched register");

  a_rng_write_ignored: assert property (
    reg_wr && sel_lat_rng && !refresh |=> $stable(latched_bidirectional_range))
    else $error("write altered latched range");

  a_act_write_ignored: assert property (
    reg_wr && sel_act_dis && !refresh |=> $stable(active_channel_disable))
    else $error("write altered active disable");

  // Main scenarios the bench is expected to reach
  c_refresh_twice: cover property (
    refresh ##1 !refresh [*2] ##1 refresh);

  c_read_latched: cover property (
    reg_rd && sel_lat_rng && latched_bidirectional_range != 8'h00);

  c_write_refresh: cover property (
    wr_pend_dis ##1 refresh);

  c_valid_again: cover property (
    $rose(latched_valid));

  c_unmapped_read: cover property (
    reg_rd && !any_sel);
endmodule

/* testbench/reg_host_model.sv */
// Host side of the register port: one-cycle strobes launched on the falling edge.
// Assumes the device samples strobes on the rising edge of sys_clk.
`timescale 1ns/1ps
module reg_host_model (
  input  wire logic                 sys_clk,
  input  wire logic                 latched_valid,
  output logic                      reg_wr,
  output logic                      reg_rd,
  output logic                      refresh,
  output setting_id_pkg::reg_byte_t reg_addr,
  output setting_id_pkg::reg_byte_t reg_wdata
);
  import setting_id_pkg::*;
  initial begin
    {reg_wr, reg_rd, refresh} = 3'b000;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // Released address and data show the inverse so stale values never look valid
  task automatic put(input reg_byte_t a, input reg_byte_t d, input logic rd, input logic rf);
    @(negedge sys_clk);
    {reg_wr, reg_rd, refresh} = {~rd & ~rf, rd, rf};
    reg_addr = a;
    reg_wdata = d;
    @(negedge sys_clk);
    {reg_wr, reg_rd, refresh} = 3'b000;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // Waits until the settle window has closed, but for no more than 8 falling edges
  task automatic await_valid();
    for (int i = 0; i < 8 && latched_valid !== 1'b1; i++) @(negedge sys_clk);
  endtask
endmodule

/* testbench/testbench.sv */
// Self-checking bench for the latched setting and identification registers.
// Assumes reg_host_model drives the port and sys_clk runs at 10 MHz.
`timescale 1ns/1ps
module testbench;
  import setting_id_pkg::*;
  localparam reg_byte_t PROD   = 8'h61;  // Arbitrary value
  localparam reg_byte_t MAKER  = 8'h4E;  // Arbitrary value
  localparam reg_byte_t REV    = 8'h09;  // Arbitrary value
  localparam int        SETTLE = 20;
  logic       sys_clk, resetn, reg_wr, reg_rd, refresh, reg_hit, latched_valid;
  reg_byte_t  reg_addr, reg_wdata, reg_rdata;
  chan_bits_t skip, sense, busv;
  int         fail_count, comparisons, cycles;

  reg_host_model host (.sys_clk(sys_clk), .latched_valid(latched_valid), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .refresh(refresh), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  latched_setting_and_id_regs #(.PRODUCT_CODE(PROD), .MAKER_CODE(MAKER), .DIE_REV_CODE(REV),
    .SETTLE_COUNT(SETTLE)) dut (.sys_clk(sys_clk), .resetn(resetn), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .refresh(refresh),
    .reg_rdata(reg_rdata), .reg_hit(reg_hit), .channel_skip_bit(skip),
    .sense_bipolar_bit(sense), .busv_bipolar_bit(busv), .latched_valid(latched_valid));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic close_out();
    if (fail_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      close_out();
    end
  end

  task automatic chk(input string what, input reg_byte_t exp, input reg_byte_t got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rdc(input reg_byte_t a, input reg_byte_t exp, input logic hit);
    host.put(a, 8'h00, 1'b1, 1'b0);
    chk("read data", exp, reg_rdata);
    chk("read hit", {7'h00, hit}, {7'h00, reg_hit});
  endtask

  task automatic id_and_reset_values();
    rdc(8'hFD, PROD, 1'b1);
    rdc(8'hFE, MAKER, 1'b1);
    rdc(8'hFF, REV, 1'b1);
    rdc(8'h30, 8'h00, 1'b0);
    rdc(8'h26, 8'h00, 1'b1);
    chk("valid idle", 8'h01, {7'h00, latched_valid});
  endtask

  task automatic writes_ignored();
    host.put(8'h25, 8'hFF, 1'b0, 1'b0);
    host.put(8'h26, 8'hFF, 1'b0, 1'b0);
    host.put(8'hFF, 8'h00, 1'b0, 1'b0);
    rdc(8'h25, 8'h00, 1'b1);
    rdc(8'h26, 8'h00, 1'b1);
    rdc(8'hFF, REV, 1'b1);
  endtask

  // Two refreshes: the first latches the old active set, the second the new one
  task automatic refresh_chain();
    host.put(8'h1C, 8'hC7, 1'b0, 1'b0);
    host.put(8'h1D, 8'hA6, 1'b0, 1'b0);
    rdc(8'h22, 8'h00, 1'b1);
    host.put(8'h00, 8'h00, 1'b0, 1'b1);
    chk("valid after refresh", 8'h00, {7'h00, latched_valid});
    rdc(8'h22, 8'hC0, 1'b1);
    rdc(8'h25, 8'h00, 1'b1);
    host.put(8'h00, 8'h00, 1'b0, 1'b1);
    repeat (SETTLE - 4) @(negedge sys_clk);
    chk("valid in settle", 8'h00, {7'h00, latched_valid});
    host.await_valid();
    chk("valid settled", 8'h01, {7'h00, latched_valid});
    rdc(8'h25, 8'hC0, 1'b1);
    rdc(8'h26, 8'hA6, 1'b1);
    chk("skip bits", 8'h03, {4'h0, skip});
    chk("sense bits", 8'h05, {4'h0, sense});
    chk("busv bits", 8'h06, {4'h0, busv});
  endtask

  initial begin
    {fail_count, comparisons, cycles} = '0;
    resetn = 1'b0;
    repeat (5) @(negedge sys_clk);
    resetn = 1'b1;
    id_and_reset_values();
    writes_ignored();
    refresh_chain();
    close_out();
  end
endmodule
